//--- rtl/dma_regs.svh
/*
 * Register offsets, bit positions and reset values of the DMA channel
 * control block. Assumes byte addresses on an 8-bit Wishbone address.
 */
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define CTRL_BASE 8'h00
`define CTRL_STRIDE 8'h04
`define IRQ_STAT_OFS 8'h40
`define IRQ_MASK_OFS 8'h44

// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define CTRL_ACTIVE_BIT 15
`define CTRL_CHAIN_DIR_BIT 8
`define CTRL_ON_BIT 7
`define CTRL_EWO_BIT 6
`define CTRL_CHAIN_ALLOW_BIT 5
`define CTRL_REARM_BIT 4
`define CTRL_SEEN_BIT 2
`define CTRL_PRI_LSB 0
`define CTRL_PRI_MSB 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET 32'h0000_0000
`define IRQ_MASK_RESET 32'h0000_0000

`endif

//--- rtl/dma_pkg.sv
/*
 * Types shared by the DMA channel control block and its arbiter.
 * Assumes the constants of dma_regs.svh are included where needed.
 */
package dma_pkg;

    typedef logic [1:0] prio_t;

    typedef enum logic [0:0] {
        WB_IDLE = 1'b0,
        WB_ACK = 1'b1
    } wb_state_t;

    typedef struct packed {
        logic chain_dir;
        logic channel_on;
        logic events_when_off;
        logic chain_allow;
        logic auto_rearm;
        prio_t channel_priority;
    } ch_cfg_t;

endpackage

//--- rtl/arb_if.sv
/*
 * Request and grant bundle between the channel control and its arbiter.
 * Assumes both ends run on the same clock; the bundle is combinational.
 */
`timescale 1ns/10ps

interface arb_if
    import dma_pkg::*;
#(
    parameter int N = 4,
    parameter int IDX_W = (N > 1) ? $clog2(N) : 1
);
    logic [N-1:0] req;
    prio_t pri [N];
    logic [IDX_W-1:0] win_idx;
    logic win_valid;

    modport requester (output req, output pri, input win_idx, input win_valid);
    modport arbiter (input req, input pri, output win_idx, output win_valid);
endinterface

//--- rtl/dma_arbiter.sv
/*
 * Fixed selection among requesting channels: highest priority field wins,
 * ties go to the lowest channel number. Purely combinational.
 */
`timescale 1ns/10ps

module dma_arbiter
    import dma_pkg::*;
#(
    parameter int N = 4,
    parameter int IDX_W = (N > 1) ? $clog2(N) : 1
)(
    arb_if.arbiter arb
);

    // ----------------------------------------
    // Selection
    // ----------------------------------------
    // Scan downward with >= so the lowest index keeps a tie
    always_comb
    begin
        arb.win_valid = 1'b0;
        arb.win_idx = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (arb.req[i] && (!arb.win_valid || arb.pri[i] >= arb.pri[arb.win_idx]))
            begin
                arb.win_valid = 1'b1;
                arb.win_idx = IDX_W'(i);
            end
        end
    end

endmodule

//--- rtl/dma_channel_control.sv
/*
 * Control and status of N DMA channels: enable and suspend, busy status,
 * automatic re-arm, chaining to neighbours, start/abort event capture,
 * priority arbitration and a block-done interrupt, behind a classic
 * Wishbone slave.
 *
 * Assumes the transfer datapath shares clk, follows the grant, raises
 * txn_busy while a transaction of the granted channel runs and pulses
 * block_done for one cycle when a channel's block is complete.
 * Assumes start_evt and abort_evt are one-cycle pulses made on clk, so
 * they pass no synchroniser.
 * Assumes the bus master holds its request until ack comes, one cycle
 * after the request is taken.
 * Limitation: the first and last channels have one neighbour each, so
 * chaining stops at the ends of the row.
 */
`timescale 1ns/10ps
`include "dma_regs.svh"

module dma_channel_control
    import dma_pkg::*;
#(
    parameter int N = 4,
    parameter int IDX_W = (N > 1) ? $clog2(N) : 1
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [N-1:0] start_evt,
    input wire logic [N-1:0] abort_evt,
    input wire logic [N-1:0] block_done,
    input wire logic txn_busy,
    output logic grant_valid,
    output logic [IDX_W-1:0] grant_idx,
    output logic irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Byte address of a channel's control word
    function automatic logic [7:0] ctrl_addr(input int ch);
        ctrl_addr = 8'(`CTRL_BASE + ch * `CTRL_STRIDE);
    endfunction

    // Assemble one control word; unused bits stay zero
    function automatic logic [31:0] ctrl_word(input ch_cfg_t c, input logic act,
                                              input logic seen);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CTRL_ACTIVE_BIT] = act;
        w[`CTRL_CHAIN_DIR_BIT] = c.chain_dir;
        w[`CTRL_ON_BIT] = c.channel_on;
        w[`CTRL_EWO_BIT] = c.events_when_off;
        w[`CTRL_CHAIN_ALLOW_BIT] = c.chain_allow;
        w[`CTRL_REARM_BIT] = c.auto_rearm;
        w[`CTRL_SEEN_BIT] = seen;
        w[`CTRL_PRI_MSB:`CTRL_PRI_LSB] = c.channel_priority;
        ctrl_word = w;
    endfunction

    // Zero-extend a per-channel vector to a bus word
    function automatic logic [31:0] low_word(input logic [N-1:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[N-1:0] = v;
        low_word = w;
    endfunction

    // Clear first, then set, so an event in the clearing cycle survives
    function automatic logic [N-1:0] set_wins(input logic [N-1:0] cur,
                                              input logic [N-1:0] clr,
                                              input logic [N-1:0] hit);
        set_wins = (cur & ~clr) | hit;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    // Per-channel configuration fields
    ch_cfg_t cfg_reg [N];
    ch_cfg_t cfg_next [N];

    // Event-seen and pending-start flags, one per channel
    logic [N-1:0] seen_reg;
    logic [N-1:0] seen_next;
    logic [N-1:0] pend_reg;
    logic [N-1:0] pend_next;

    // Block-done status and interrupt mask
    logic [N-1:0] stat_reg;
    logic [N-1:0] stat_next;
    logic [N-1:0] mask_reg;
    logic [N-1:0] mask_next;

    // Bus answer and read data
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wb_state_t wb_state_reg;
    wb_state_t wb_state_next;

    // Grant as seen by the datapath
    logic grant_valid_reg;
    logic [IDX_W-1:0] grant_idx_reg;

    arb_if #(.N(N), .IDX_W(IDX_W)) arb ();

    dma_arbiter #(.N(N), .IDX_W(IDX_W)) u_arb (
        .arb(arb.arbiter)
    );

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // A request is served once: the access takes effect as ack rises
    // Holding stb past ack starts a new access two cycles later
    wire logic bus_req = wb_cyc && wb_stb && (wb_state_reg == WB_IDLE);
    wire logic bus_wr = bus_req && wb_we;
    wire logic bus_rd = bus_req && !wb_we;
    wire logic hit_stat = (wb_adr == `IRQ_STAT_OFS);
    wire logic hit_mask = (wb_adr == `IRQ_MASK_OFS);
    // Status read-clear and mask write strobes
    wire logic stat_rd_clr = bus_rd && hit_stat;
    wire logic mask_wr = bus_wr && hit_mask && wb_sel[0];
    logic [N-1:0] hit_ctrl;
    logic [N-1:0] wr_lo;
    logic [N-1:0] wr_hi;
    logic [31:0] ctrl_view [N];
    logic [N-1:0] active;
    logic [N-1:0] ev_ok;
    logic [N-1:0] start_ok;
    logic [N-1:0] abort_ok;
    logic [N-1:0] chain_hit;
    logic [N-1:0] mine;
    logic [N-1:0] lower_done;
    logic [N-1:0] higher_done;

    // Neighbour completions; each end of the channel row has none on its outer side
    assign lower_done = {1'b0, block_done[N-1:1]};
    assign higher_done = {block_done[N-2:0], 1'b0};

    // Per-channel decode, status and event qualification
    for (genvar g = 0; g < N; g++)
    begin : g_ch
        assign hit_ctrl[g] = (wb_adr == ctrl_addr(g));
        assign mine[g] = grant_valid_reg && (grant_idx_reg == IDX_W'(g));
        // Busy stays up until a suspended channel's transaction drains
        assign active[g] = cfg_reg[g].channel_on || (mine[g] && txn_busy);
        assign ev_ok[g] = cfg_reg[g].channel_on || cfg_reg[g].events_when_off;
        assign start_ok[g] = start_evt[g] && ev_ok[g];
        assign abort_ok[g] = abort_evt[g] && ev_ok[g];
        // Direction is looked at only when chaining is allowed
        assign chain_hit[g] = cfg_reg[g].chain_allow &&
                              (cfg_reg[g].chain_dir ? lower_done[g] : higher_done[g]);
        // Byte lane 0 carries bits 7:0, lane 1 the chain direction
        assign wr_lo[g] = bus_wr && hit_ctrl[g] && wb_sel[0];
        assign wr_hi[g] = bus_wr && hit_ctrl[g] && wb_sel[1];
        // Read view of each control word
        assign ctrl_view[g] = ctrl_word(cfg_reg[g], active[g], seen_reg[g]);
        // Requests only count while the channel is on
        assign arb.req[g] = cfg_reg[g].channel_on && pend_reg[g];
        assign arb.pri[g] = cfg_reg[g].channel_priority;
    end

    // ----------------------------------------
    // Read data selection
    // ----------------------------------------
    // Unmapped addresses read zero and are still acknowledged
    // Data is captured as the request is taken and held while ack stands
    always_comb
    begin
        rdata_next = rdata_reg;
        if (bus_rd)
        begin
            rdata_next = 32'h0000_0000;
            if (hit_stat)
                rdata_next = low_word(stat_reg);
            if (hit_mask)
                rdata_next = low_word(mask_reg);
            for (int i = 0; i < N; i++)
            begin
                if (hit_ctrl[i])
                    rdata_next = ctrl_view[i];
            end
        end
    end

    // ----------------------------------------
    // Channel control next state
    // ----------------------------------------
    // Software writes first, then hardware clears, then hardware sets,
    // so a chain trigger in the same cycle as a clear is never lost
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            cfg_next[i] = cfg_reg[i];
            if (wr_lo[i])
            begin
                cfg_next[i].channel_on = wb_dat_w[`CTRL_ON_BIT];
                cfg_next[i].events_when_off = wb_dat_w[`CTRL_EWO_BIT];
                cfg_next[i].chain_allow = wb_dat_w[`CTRL_CHAIN_ALLOW_BIT];
                cfg_next[i].auto_rearm = wb_dat_w[`CTRL_REARM_BIT];
                cfg_next[i].channel_priority = wb_dat_w[`CTRL_PRI_MSB:`CTRL_PRI_LSB];
            end
            // Busy and event-seen are read-only; other upper bits are absent
            if (wr_hi[i])
                cfg_next[i].chain_dir = wb_dat_w[`CTRL_CHAIN_DIR_BIT];
            // Re-arm keeps the channel on through its own completion
            if (block_done[i] && !cfg_reg[i].auto_rearm)
                cfg_next[i].channel_on = 1'b0;
            if (abort_ok[i])
                cfg_next[i].channel_on = 1'b0;
            if (chain_hit[i])
                cfg_next[i].channel_on = 1'b1;
        end
    end

    // ----------------------------------------
    // Event, pending and interrupt next state
    // ----------------------------------------
    // Every flag here lets its set win over its clear
    always_comb
    begin
        mask_next = mask_reg;
        // Re-arm leaves channel-on alone; the pending start and the seen flag are used up
        pend_next = set_wins(pend_reg, block_done | abort_ok, start_ok);
        seen_next = set_wins(seen_reg, block_done, start_ok | abort_ok);
        // A status read clears what it returned; a new completion still sets
        stat_next = set_wins(stat_reg, {N{stat_rd_clr}}, block_done);
        if (mask_wr)
            mask_next = wb_dat_w[N-1:0];
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // One cycle answer, then one idle cycle to let ack fall
    always_comb
    begin
        wb_state_next = wb_state_reg;
        unique case (wb_state_reg)
            WB_IDLE:
                if (bus_req)
                    wb_state_next = WB_ACK;
            WB_ACK:
                wb_state_next = WB_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Channel configuration
    // Every field resets to zero, so all channels start off
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < N; i++)
                cfg_reg[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
                cfg_reg[i] <= cfg_next[i];
        end
    end

    // Flags, mask, bus state and read data
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            seen_reg <= '0;
            pend_reg <= '0;
            stat_reg <= '0;
            mask_reg <= '0;
            rdata_reg <= 32'h0000_0000;
            wb_state_reg <= WB_IDLE;
        end
        else
        begin
            seen_reg <= seen_next;
            pend_reg <= pend_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
            wb_state_reg <= wb_state_next;
        end
    end

    // Grant is frozen while a transaction runs so suspend cannot cut it
    // The grant lags the request by one cycle, traded for a clean output
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            grant_valid_reg <= 1'b0;
            grant_idx_reg <= '0;
        end
        else if (!txn_busy)
        begin
            grant_valid_reg <= arb.win_valid;
            grant_idx_reg <= arb.win_idx;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Ack, read data and grant all come straight from flip-flops
    assign wb_ack = (wb_state_reg == WB_ACK);
    assign wb_dat_r = rdata_reg;
    assign grant_valid = grant_valid_reg;
    assign grant_idx = grant_idx_reg;

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Level output, high while an unmasked completion is unread;
    // a decode of two registers, so a mask write acts at once
    assign irq = |(stat_reg & mask_reg);

endmodule

//--- dv/dma_channel_control_chk.sv
/* Checker on the ports of dma_channel_control.
   Assumes one clock and an async active-low reset. */
`timescale 1ns/10ps
module dma_channel_control_chk #(
    parameter int N = 4,
    parameter int IDX_W = 2
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    input wire logic [N-1:0] start_evt,
    input wire logic [N-1:0] abort_evt,
    input wire logic [N-1:0] block_done,
    input wire logic txn_busy,
    input wire logic grant_valid,
    input wire logic [IDX_W-1:0] grant_idx,
    input wire logic irq
);
    // ------
    // Properties
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // A taken request answers with exactly one ack cycle
    sequence s_taken;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence s_ack_once;
        wb_ack ##1 !wb_ack;
    endsequence
    a_bus_answer: assert property (s_taken |=> s_ack_once)
        else $error("ack shape wrong");
    a_ack_cause: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    // Read data looks back at the address taken one cycle earlier
    a_unused_zero: assert property (
        wb_ack && $past(!wb_we && wb_adr < 8'h10) |->
        wb_dat_r[31:16] == 16'h0 && wb_dat_r[14:9] == 6'h0 && !wb_dat_r[3])
        else $error("unused bits set");
    a_busy_on: assert property (
        wb_ack && $past(!wb_we && wb_adr < 8'h10) && wb_dat_r[7] |-> wb_dat_r[15])
        else $error("busy low while on");
    a_unmapped_zero: assert property (
        wb_ack && $past(!wb_we && wb_adr[7]) |-> wb_dat_r == 32'h0)
        else $error("unmapped read not zero");
    a_status_width: assert property (
        wb_ack && $past(!wb_we && wb_adr == 8'h40) |-> (wb_dat_r >> N) == 32'h0)
        else $error("status bits above channels");
    // Grant frozen mid-transaction, which is what makes suspend safe
    a_grant_hold: assert property (
        grant_valid && txn_busy |=> grant_valid && $stable(grant_idx))
        else $error("grant moved while busy");
    // Level interrupt rises after a completion or on a write ack, falls only on an ack
    a_irq_rise: assert property (
        $rose(irq) |-> (wb_ack && $past(wb_we)) || $past(|block_done))
        else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> wb_ack)
        else $error("irq fell without access");
endmodule

//--- dv/tb.sv
/* Self-checking bench for dma_channel_control: registers, events, grants,
   chaining, interrupt. Assumes package and design are compiled first. */
`timescale 1ns/10ps
module tb;
    import dma_pkg::*;
    // ------
    // Signals
    // ------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [3:0] start_evt = 4'h0;
    logic [3:0] abort_evt = 4'h0;
    logic [3:0] block_done = 4'h0;
    logic txn_busy = 1'b0;
    logic grant_valid;
    logic [1:0] grant_idx;
    logic irq;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int w;
    logic [31:0] exp_q [$];
    prio_t pri [4];
    logic [3:0] rem;
    // Chaining cases: control word, done pulses, read-back
    logic [31:0] chain_tab [4][3] = '{'{32'h120, 32'h4, 32'h81A0},
        '{32'h20, 32'h4, 32'h20}, '{32'h20, 32'h1, 32'h80A0}, '{32'h100, 32'h5, 32'h100}};
    dma_channel_control #(.N(4)) dut_u (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .start_evt(start_evt),
        .abort_evt(abort_evt), .block_done(block_done), .txn_busy(txn_busy),
        .grant_valid(grant_valid), .grant_idx(grant_idx), .irq(irq));
    // 50 ns clock
    always #25 clk = ~clk;
    // ------
    // Tasks
    // ------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic conclude();
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One classic cycle; held until ack is sampled, the timeout guards a hang
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat_w <= d;
        do
            @(posedge clk);
        while (wb_ack !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // One-cycle pulse: 0 start, 1 abort, else block done; then settle
    task automatic pulse(input int k, input logic [3:0] v);
        @(posedge clk);
        if (k == 0) start_evt <= v;
        else if (k == 1) abort_evt <= v;
        else block_done <= v;
        @(posedge clk);
        start_evt <= 4'h0;
        abort_evt <= 4'h0;
        block_done <= 4'h0;
        repeat (3) @(posedge clk);
    endtask
    // Read-back monitor and hang guard
    always @(posedge clk)
    begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), wb_dat_r);
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            conclude();
        end
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h4A90));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 6; k++)
            rd(8'(k < 4 ? 4 * k : 8'h30 + 4 * k), 32'h0);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, 32'h81F3);
        wr(8'h04, 32'h0);
        wr(8'h80, 32'hFFFF_FFFF);
        rd(8'h80, 32'h0);
        // Random priorities, all start together, served one by one
        for (int k = 0; k < 4; k++)
        begin
            pri[k] = prio_t'($urandom);
            wr(8'(4 * k), {24'h0, 6'h20, pri[k]});
        end
        pulse(0, 4'hF);
        rd(8'h00, {16'h0, 8'h80, 6'h21, pri[0]});
        rem = 4'hF;
        repeat (4)
        begin
            w = -1;
            for (int k = 0; k < 4; k++)
                if (rem[k] && (w < 0 || pri[k] > pri[w]))
                    w = k;
            chk("grant valid", 32'h1, 32'(grant_valid));
            chk("grant index", 32'(w), 32'(grant_idx));
            pulse(2, 4'(1 << w));
            rem[w] = 1'b0;
        end
        chk("grant valid", 32'h0, 32'(grant_valid));
        for (int k = 0; k < 4; k++)
            rd(8'(4 * k), 32'(pri[k]));
        wr(8'h44, 32'h0);
        chk("irq", 32'h0, 32'(irq));
        wr(8'h44, 32'hF);
        chk("irq", 32'h1, 32'(irq));
        rd(8'h40, 32'hF);
        chk("irq", 32'h0, 32'(irq));
        rd(8'h40, 32'h0);
        // Re-arm, then suspend in mid-transaction
        wr(8'h08, 32'h90);
        pulse(0, 4'h4);
        txn_busy <= 1'b1;
        pulse(2, 4'h4);
        rd(8'h08, 32'h8090);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h8000);
        txn_busy <= 1'b0;
        rd(8'h08, 32'h0);
        // Events while off, then abort
        wr(8'h0C, 32'h0);
        pulse(0, 4'h8);
        rd(8'h0C, 32'h0);
        wr(8'h0C, 32'h40);
        pulse(0, 4'h8);
        rd(8'h0C, 32'h44);
        wr(8'h0C, 32'hC0);
        pulse(1, 4'h8);
        rd(8'h0C, 32'h44);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, chain_tab[i][0]);
            pulse(2, chain_tab[i][1][3:0]);
            rd(8'h04, chain_tab[i][2]);
        end
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
bind dma_channel_control dma_channel_control_chk #(.N(N), .IDX_W(IDX_W)) chk_u (.clk(clk),
    .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .start_evt(start_evt), .abort_evt(abort_evt), .block_done(block_done),
    .txn_busy(txn_busy), .grant_valid(grant_valid), .grant_idx(grant_idx), .irq(irq));
